/* common/rfb_pkg.sv */
package rfb_pkg;
	// ****************************************
	// buffer geometry and frame limits
	// ****************************************
	localparam int BUF_DEPTH = 128;
	localparam logic [7:0] MAX_FRAME_LEN = 8'h7F;
	localparam logic [7:0] MIN_FRAME_LEN = 8'h01;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] META_LQI_IDX = 8'h00;
	localparam logic [7:0] META_ED_IDX = 8'h01;
	localparam logic [7:0] META_STATUS_IDX = 8'h02;

	// ****************************************
	// link command byte
	// ****************************************
	localparam int CMD_WRITE_BIT = 7;
	localparam int CMD_FRAME_BIT = 6;

	// ****************************************
	// host register map
	// ****************************************
	localparam logic [11:0] HOST_XFER_OFS = 12'h000;
	localparam logic [11:0] HOST_STAT_OFS = 12'h004;
	localparam logic [11:0] HOST_RXD_OFS = 12'h008;
	localparam int XFER_FIRST_BIT = 8;
	localparam int XFER_LAST_BIT = 9;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CS_BIT = 1;
	localparam int STAT_OK_BIT = 2;

	// ****************************************
	// link timing
	// ****************************************
	localparam int PCLK_PERIOD_NS = 10;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [2:0]
	{
		SP_CMD = 3'h1,
		SP_ADDR = 3'h2,
		SP_DATA = 3'h4
	} rfb_dev_st_e;

	typedef enum logic [3:0]
	{
		H_IDLE = 4'h1,
		H_LOW = 4'h2,
		H_HIGH = 4'h4,
		H_END = 4'h8
	} rfb_host_st_e;
endpackage

/* common/rfb_spi_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface rfb_spi_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport host (output sclk, output cs_n, output mosi, input miso);
	modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

/* design/rfb_frame_buffer_dev.sv */
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - 128-byte store, host and baseband ports
// - addresses 0x00-0x7F, one frame held
// - port conflict raises underrun event
// - host frame over 127 octets flags overflow
// - no access while in sleep
// - power-on access needs host clock running
// - data kept until write, receive, sleep, reset
// - new frame during host read flags underrun
// - host reads faster than air, checks FCS
// - host protects frame by state command
// - protection never blocks host writes
// - ack wait evaluates frames, stores none
// - only sleep or reset loses contents
// - store length, psdu, quality, energy, status
// - length byte at address zero
// - host loads frame, device inserts FCS
// - random-access writes of single bytes
// - shortest frame is length plus one
// - each port owns an address counter
// - conflicts flagged in frame mode only
// - host waits symbols before reading receive
// - first psdu byte before SFD ends
module rfb_frame_buffer_dev
	import rfb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	rfb_spi_if.dev spi,
	input wire logic trx_sleep,
	input wire logic trx_pon,
	input wire logic host_clock_output_on,
	input wire logic pll_on_protect,
	input wire logic dyn_protect_en,
	input wire logic auto_retry_wait_ack,
	input wire logic tx_auto_crc_on,
	input wire logic bb_rx_start,
	input wire logic bb_rx_valid,
	input wire logic [7:0] bb_rx_data,
	input wire logic bb_rx_end,
	input wire logic [7:0] bb_rx_lqi,
	input wire logic [7:0] bb_rx_ed,
	input wire logic [7:0] bb_rx_status,
	input wire logic bb_tx_start,
	input wire logic bb_tx_req,
	input wire logic [7:0] bb_tx_fcs,
	output logic [7:0] bb_tx_data,
	output logic bb_tx_valid,
	output logic host_access_ok,
	output logic buffer_underrun_irq
);
	// ****************************************
	// link synchronisers and edges
	// ****************************************
	logic [2:0] sclk_sync_ff;
	logic [1:0] csn_sync_ff;
	logic [1:0] mosi_sync_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic sel;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_sync_ff <= 3'h0;
			csn_sync_ff <= 2'h3;
			mosi_sync_ff <= 2'h0;
		end
		else
		begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], spi.sclk};
			csn_sync_ff <= {csn_sync_ff[0], spi.cs_n};
			mosi_sync_ff <= {mosi_sync_ff[0], spi.mosi};
		end
	end

	assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign host_access_ok = ~trx_sleep & (~trx_pon | host_clock_output_on);
	assign sel = ~csn_sync_ff[1] & host_access_ok;

	// ****************************************
	// storage
	// ****************************************
	logic [7:0] mem_ff [BUF_DEPTH];
	logic [7:0] lqi_ff;
	logic [7:0] ed_ff;
	logic [7:0] status_ff;
	logic [7:0] frame_len;
	assign frame_len = mem_ff[0];

	// ****************************************
	// host port shifter and command decode
	// ****************************************
	rfb_dev_st_e st_ff;
	logic [2:0] bit_cnt_ff;
	logic [6:0] in_sh_ff;
	logic wr_mode_ff;
	logic frame_mode_ff;
	logic [7:0] host_ptr_ff;
	logic [7:0] out_sh_ff;
	logic miso_ff;
	logic byte_done;
	logic [7:0] byte_in;
	logic [7:0] rd_idx;
	logic [7:0] meta_idx;
	logic do_load;
	logic [7:0] nxt_out;
	logic host_wr_en;
	logic host_ovf;
	logic frd_active;
	logic frd_active_ff;

	assign byte_done = sclk_rise & sel & (bit_cnt_ff == 3'h7);
	assign byte_in = {in_sh_ff, mosi_sync_ff[1]};
	assign meta_idx = rd_idx - frame_len - 8'h01;
	assign frd_active = sel & frame_mode_ff & ~wr_mode_ff & (st_ff == SP_DATA);

	always_comb
	begin
		rd_idx = host_ptr_ff;
		do_load = 1'b0;
		nxt_out = BYTE_RST;
		unique case (st_ff)
			SP_CMD:
			begin
				rd_idx = 8'h00;
				do_load = ~byte_in[CMD_WRITE_BIT] & byte_in[CMD_FRAME_BIT];
			end
			SP_ADDR:
			begin
				rd_idx = {1'b0, byte_in[6:0]};
				do_load = ~wr_mode_ff;
			end
			SP_DATA:
			begin
				do_load = ~wr_mode_ff;
			end
		endcase
		if (frame_mode_ff && st_ff == SP_DATA && rd_idx > frame_len)
		begin
			if (meta_idx == META_LQI_IDX)
				nxt_out = lqi_ff;
			else if (meta_idx == META_ED_IDX)
				nxt_out = ed_ff;
			else if (meta_idx == META_STATUS_IDX)
				nxt_out = status_ff;
		end
		else
			nxt_out = mem_ff[rd_idx[6:0]];
	end

	assign host_ovf = byte_done & (st_ff == SP_DATA) & wr_mode_ff & frame_mode_ff
		& (host_ptr_ff[7] | (host_ptr_ff == 8'h00 && byte_in > MAX_FRAME_LEN));
	assign host_wr_en = byte_done & (st_ff == SP_DATA) & wr_mode_ff
		& ~(frame_mode_ff & host_ptr_ff[7]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= SP_CMD;
			bit_cnt_ff <= 3'h0;
			in_sh_ff <= 7'h00;
			wr_mode_ff <= 1'b0;
			frame_mode_ff <= 1'b0;
			host_ptr_ff <= 8'h00;
		end
		else if (!sel)
		begin
			st_ff <= SP_CMD;
			bit_cnt_ff <= 3'h0;
		end
		else if (sclk_rise)
		begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			in_sh_ff <= byte_in[6:0];
			if (byte_done)
			begin
				unique case (st_ff)
					SP_CMD:
					begin
						wr_mode_ff <= byte_in[CMD_WRITE_BIT];
						frame_mode_ff <= byte_in[CMD_FRAME_BIT];
						st_ff <= byte_in[CMD_FRAME_BIT] ? SP_DATA : SP_ADDR;
						host_ptr_ff <= do_load ? 8'h01 : 8'h00;
					end
					SP_ADDR:
					begin
						st_ff <= SP_DATA;
						host_ptr_ff <= rd_idx + (do_load ? 8'h01 : 8'h00);
					end
					SP_DATA:
					begin
						if (frame_mode_ff)
							host_ptr_ff <= host_ptr_ff + 8'h01;
						else
							host_ptr_ff <= {1'b0, host_ptr_ff[6:0] + 7'h01};
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_sh_ff <= BYTE_RST;
			miso_ff <= 1'b0;
		end
		else if (!sel)
		begin
			out_sh_ff <= BYTE_RST;
			miso_ff <= 1'b0;
		end
		else if (byte_done)
			out_sh_ff <= do_load ? nxt_out : BYTE_RST;
		else if (sclk_fall)
		begin
			miso_ff <= out_sh_ff[7];
			out_sh_ff <= {out_sh_ff[6:0], 1'b0};
		end
	end
	assign spi.miso = miso_ff;

	// ****************************************
	// baseband port
	// ****************************************
	logic [7:0] bb_ptr_ff;
	logic rx_act_ff;
	logic tx_act_ff;
	logic held_ff;
	logic rx_go;
	logic bb_wr_en;
	logic [7:0] tx_data_ff;
	logic tx_valid_ff;
	logic fcs_slot;

	assign rx_go = bb_rx_start & ~pll_on_protect & ~auto_retry_wait_ack
		& ~(dyn_protect_en & held_ff);
	assign bb_wr_en = rx_act_ff & bb_rx_valid & ~bb_ptr_ff[7]
		& ~(bb_ptr_ff == 8'h00 && bb_rx_data < MIN_FRAME_LEN);
	assign fcs_slot = tx_auto_crc_on & (bb_ptr_ff != 8'h00) & (bb_ptr_ff + 8'h01 >= frame_len);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bb_ptr_ff <= 8'h00;
			rx_act_ff <= 1'b0;
			tx_act_ff <= 1'b0;
			tx_data_ff <= BYTE_RST;
			tx_valid_ff <= 1'b0;
		end
		else
		begin
			tx_valid_ff <= 1'b0;
			if (rx_go)
			begin
				bb_ptr_ff <= 8'h00;
				rx_act_ff <= 1'b1;
				tx_act_ff <= 1'b0;
			end
			else if (bb_tx_start)
			begin
				bb_ptr_ff <= 8'h00;
				tx_act_ff <= 1'b1;
				rx_act_ff <= 1'b0;
			end
			else if (bb_rx_end || (rx_act_ff && bb_rx_valid && !bb_wr_en))
				rx_act_ff <= 1'b0;
			else if (bb_wr_en)
				bb_ptr_ff <= bb_ptr_ff + 8'h01;
			else if (tx_act_ff && bb_tx_req)
			begin
				tx_data_ff <= fcs_slot ? bb_tx_fcs : mem_ff[bb_ptr_ff[6:0]];
				tx_valid_ff <= 1'b1;
				bb_ptr_ff <= bb_ptr_ff + 8'h01;
				tx_act_ff <= bb_ptr_ff != frame_len;
			end
		end
	end
	assign bb_tx_data = tx_data_ff;
	assign bb_tx_valid = tx_valid_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < BUF_DEPTH; i++)
				mem_ff[i] <= BYTE_RST;
		end
		else if (trx_sleep)
		begin
			for (int i = 0; i < BUF_DEPTH; i++)
				mem_ff[i] <= BYTE_RST;
		end
		else
		begin
			if (bb_wr_en)
				mem_ff[bb_ptr_ff[6:0]] <= bb_rx_data;
			if (host_wr_en)
				mem_ff[host_ptr_ff[6:0]] <= byte_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lqi_ff <= BYTE_RST;
			ed_ff <= BYTE_RST;
			status_ff <= BYTE_RST;
		end
		else if (trx_sleep)
		begin
			lqi_ff <= BYTE_RST;
			ed_ff <= BYTE_RST;
			status_ff <= BYTE_RST;
		end
		else if (rx_act_ff && bb_rx_end)
		begin
			lqi_ff <= bb_rx_lqi;
			ed_ff <= bb_rx_ed;
			status_ff <= bb_rx_status;
		end
	end

	// frame held until host has read it; set beats clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_ff <= 1'b0;
			frd_active_ff <= 1'b0;
		end
		else
		begin
			frd_active_ff <= frd_active;
			if (rx_act_ff && bb_rx_end)
				held_ff <= 1'b1;
			else if ((frd_active_ff && !frd_active) || trx_sleep)
				held_ff <= 1'b0;
		end
	end

	// ****************************************
	// underrun event
	// ****************************************
	logic conflict;
	logic irq_ff;
	assign conflict = (rx_go & frd_active)
		| (frd_active & byte_done & rx_act_ff & (rd_idx >= bb_ptr_ff))
		| (tx_act_ff & bb_tx_req & sel & frame_mode_ff & wr_mode_ff
			& (st_ff == SP_DATA) & (bb_ptr_ff >= host_ptr_ff));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= conflict | host_ovf;
	end
	assign buffer_underrun_irq = irq_ff;
endmodule
`default_nettype wire

/* design/rfb_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
module rfb_spi_host
	import rfb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic radio_access_ok,
	rfb_spi_if.host spi
);
	// ****************************************
	// register access
	// ****************************************
	rfb_host_st_e st_ff;
	logic [7:0] rxd_ff;
	logic [31:0] prdata_ff;
	logic mapped;
	logic start;

	assign mapped = (paddr == HOST_XFER_OFS) | (paddr == HOST_STAT_OFS) | (paddr == HOST_RXD_OFS);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign start = psel & penable & pwrite & (paddr == HOST_XFER_OFS)
		& (st_ff == H_IDLE) & radio_access_ok;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h00000000;
		else if (psel && !penable)
		begin
			prdata_ff <= 32'h00000000;
			if (paddr == HOST_STAT_OFS)
			begin
				prdata_ff[STAT_BUSY_BIT] <= st_ff != H_IDLE;
				prdata_ff[STAT_CS_BIT] <= ~spi.cs_n;
				prdata_ff[STAT_OK_BIT] <= radio_access_ok;
			end
			else if (paddr == HOST_RXD_OFS)
				prdata_ff[7:0] <= rxd_ff;
		end
	end
	assign prdata = prdata_ff;

	// ****************************************
	// link master
	// ****************************************
	logic [1:0] miso_sync_ff;
	logic [3:0] div_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] rx_sh_ff;
	logic last_ff;
	logic sclk_ff;
	logic csn_ff;
	logic mosi_ff;
	logic half_done;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			miso_sync_ff <= 2'h0;
		else
			miso_sync_ff <= {miso_sync_ff[0], spi.miso};
	end

	// divider sets link rate above 1 MHz
	assign half_done = div_ff == SCLK_HALF_LAST;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_ff <= 4'h0;
		else if (st_ff == H_IDLE || half_done)
			div_ff <= 4'h0;
		else
			div_ff <= div_ff + 4'h1;
	end

	// bytes sent in order given by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= H_IDLE;
			bit_cnt_ff <= 3'h0;
			sh_ff <= BYTE_RST;
			rx_sh_ff <= BYTE_RST;
			rxd_ff <= BYTE_RST;
			last_ff <= 1'b0;
			sclk_ff <= 1'b0;
			csn_ff <= 1'b1;
			mosi_ff <= 1'b0;
		end
		else
		begin
			unique case (st_ff)
				H_IDLE:
				begin
					if (start)
					begin
						sh_ff <= pwdata[7:0];
						mosi_ff <= pwdata[7];
						last_ff <= pwdata[XFER_LAST_BIT];
						bit_cnt_ff <= 3'h0;
						st_ff <= H_LOW;
						if (pwdata[XFER_FIRST_BIT])
							csn_ff <= 1'b0;
					end
				end
				H_LOW:
				begin
					if (half_done)
					begin
						sclk_ff <= 1'b1;
						rx_sh_ff <= {rx_sh_ff[6:0], miso_sync_ff[1]};
						st_ff <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					if (half_done)
					begin
						sclk_ff <= 1'b0;
						if (bit_cnt_ff == 3'h7)
						begin
							rxd_ff <= rx_sh_ff;
							st_ff <= last_ff ? H_END : H_IDLE;
						end
						else
						begin
							bit_cnt_ff <= bit_cnt_ff + 3'h1;
							mosi_ff <= sh_ff[6];
							sh_ff <= {sh_ff[6:0], 1'b0};
							st_ff <= H_LOW;
						end
					end
				end
				H_END:
				begin
					if (half_done)
					begin
						csn_ff <= 1'b1;
						st_ff <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign spi.sclk = sclk_ff;
	assign spi.cs_n = csn_ff;
	assign spi.mosi = mosi_ff;
endmodule
`default_nettype wire

/* tb/rfb_spi_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module rfb_spi_asserts
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic trx_sleep,
	input wire logic trx_pon,
	input wire logic host_clock_output_on,
	input wire logic host_access_ok,
	input wire logic buffer_underrun_irq
);
	logic [2:0] bits_ff;
	logic sclk_q_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********
	// link framing
	// ********
	sequence high_half;
		sclk [*8] ##1 !sclk;
	endsequence
	sequence lead_in;
		!sclk [*7] ##[1:3] sclk;
	endsequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bits_ff <= 3'h0;
			sclk_q_ff <= 1'b0;
		end
		else
		begin
			sclk_q_ff <= sclk;
			if (sclk && !sclk_q_ff)
				bits_ff <= bits_ff + 3'h1;
		end
	end
	idle_clock_low_a: assert property (cs_n |-> !sclk)
		else $error("link clock high while deselected");
	clock_high_half_a: assert property ($rose(sclk) |-> high_half)
		else $error("link clock high phase not eight cycles");
	data_stable_a: assert property (sclk && $past(sclk) |-> $stable(mosi) && $stable(miso))
		else $error("link data moved while clock high");
	select_lead_a: assert property ($fell(cs_n) |-> lead_in)
		else $error("first clock edge not eight cycles after select");
	whole_bytes_a: assert property ($rose(cs_n) |-> bits_ff == 3'h0)
		else $error("session ended inside a byte");
	access_gate_a: assert property (host_access_ok == (!trx_sleep && (!trx_pon || host_clock_output_on)))
		else $error("host access gate wrong");
	irq_pulse_a: assert property (buffer_underrun_irq |=> !buffer_underrun_irq)
		else $error("underrun flag longer than one cycle");
	quiet_miso_a: assert property (!host_access_ok [*2] |-> !miso)
		else $error("device drives data while access is off");
endmodule
`default_nettype wire

/* tb/radio_frame_buffer_test.sv */
`timescale 1ns/100ps
`default_nettype none
module radio_frame_buffer_test
	import rfb_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic trx_sleep, trx_pon, host_clock_output_on, pll_on_protect, dyn_protect_en;
	logic auto_retry_wait_ack, tx_auto_crc_on, bb_rx_start, bb_rx_valid, bb_rx_end;
	logic bb_tx_start, bb_tx_req, bb_tx_valid, host_access_ok, buffer_underrun_irq;
	logic [7:0] bb_rx_data, bb_rx_lqi, bb_rx_ed, bb_rx_status, bb_tx_fcs, bb_tx_data;
	int fails, n_compared, irqs;
	rfb_spi_if spi_bus();
	rfb_spi_host rfb_spi_host_inst
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .radio_access_ok(host_access_ok), .spi(spi_bus)
	);
	rfb_frame_buffer_dev rfb_frame_buffer_dev_inst
	(
		.pclk, .presetn, .spi(spi_bus), .trx_sleep, .trx_pon, .host_clock_output_on,
		.pll_on_protect, .dyn_protect_en, .auto_retry_wait_ack, .tx_auto_crc_on,
		.bb_rx_start, .bb_rx_valid, .bb_rx_data, .bb_rx_end, .bb_rx_lqi, .bb_rx_ed,
		.bb_rx_status, .bb_tx_start, .bb_tx_req, .bb_tx_fcs, .bb_tx_data, .bb_tx_valid,
		.host_access_ok, .buffer_underrun_irq
	);
	rfb_spi_asserts rfb_spi_asserts_inst
	(
		.pclk, .presetn, .sclk(spi_bus.sclk), .cs_n(spi_bus.cs_n), .mosi(spi_bus.mosi),
		.miso(spi_bus.miso), .trx_sleep, .trx_pon, .host_clock_output_on,
		.host_access_ok, .buffer_underrun_irq
	);
	always #(PCLK_PERIOD_NS / 2) pclk = ~pclk;
	always @(posedge pclk)
		if (buffer_underrun_irq === 1'b1)
			irqs++;
	// ********
	// shared tasks
	// ********
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic give_up;
		fails++;
		results();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp(input logic [7:0] g[$], input logic [7:0] x[$]);
		foreach (x[i])
			chk(g[i], x[i]);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			give_up();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] b, input logic first, input logic last,
		output logic [7:0] r);
		logic [31:0] q;
		logic e;
		int n;
		apb(1'b1, HOST_XFER_OFS, {22'h0, last, first, b}, q, e);
		n = 0;
		do
		begin
			apb(1'b0, HOST_STAT_OFS, 32'h0, q, e);
			n++;
		end
		while (q[STAT_BUSY_BIT] !== 1'b0 && n < 200);
		if (n >= 200)
			give_up();
		apb(1'b0, HOST_RXD_OFS, 32'h0, q, e);
		r = q[7:0];
	endtask
	task automatic sess(input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] r;
		rx = {};
		foreach (tx[i])
		begin
			xfer(tx[i], i == 0, i == tx.size() - 1, r);
			rx.push_back(r);
		end
	endtask
	task automatic rx_frame(input logic [7:0] f[$]);
		bb_rx_start <= 1'b1;
		@(posedge pclk);
		bb_rx_start <= 1'b0;
		foreach (f[i])
		begin
			bb_rx_valid <= 1'b1;
			bb_rx_data <= f[i];
			@(posedge pclk);
		end
		bb_rx_valid <= 1'b0;
		bb_rx_end <= 1'b1;
		@(posedge pclk);
		bb_rx_end <= 1'b0;
	endtask
	// ********
	// scenarios
	// ********
	task automatic s_store;
		logic [7:0] r[$];
		sess({8'hC0, 8'h03, 8'hA1, 8'hA2, 8'hA3}, r);
		sess({8'h80, 8'h02, 8'h5C}, r);
		sess({8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, r);
		cmp(r[2:$], {8'h03, 8'hA1, 8'h5C, 8'hA3});
		chk(irqs, 0);
	endtask
	task automatic s_tx;
		logic [7:0] m[4];
		m = '{8'h03, 8'hA1, 8'h5C, 8'hA3};
		for (int c = 0; c < 2; c++)
		begin
			tx_auto_crc_on <= c[0];
			bb_tx_start <= 1'b1;
			@(posedge pclk);
			bb_tx_start <= 1'b0;
			for (int i = 0; i < 4; i++)
			begin
				bb_tx_req <= 1'b1;
				@(posedge pclk);
				bb_tx_req <= 1'b0;
				@(negedge pclk);
				chk(bb_tx_valid, 1);
				chk(bb_tx_data, (c == 1 && i >= 2) ? bb_tx_fcs : m[i]);
				@(posedge pclk);
			end
		end
	endtask
	task automatic s_rx;
		logic [7:0] r[$];
		logic [7:0] f[$];
		f = {8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		rx_frame({8'h02, 8'hD1, 8'hD2});
		sess(f, r);
		cmp(r[1:$], {8'h02, 8'hD1, 8'hD2, 8'h55, 8'h66, 8'h77});
		for (int p = 0; p < 2; p++)
		begin
			auto_retry_wait_ack <= (p == 0);
			pll_on_protect <= (p == 1);
			rx_frame({8'h01, 8'hEE});
		end
		sess(f, r);
		cmp(r[1:$], {8'h02, 8'hD1, 8'hD2, 8'h55, 8'h66, 8'h77});
		sess({8'h80, 8'h01, 8'h3C}, r);
		sess({8'h00, 8'h01, 8'h00}, r);
		chk(r[2], 8'h3C);
		auto_retry_wait_ack <= 1'b0;
		pll_on_protect <= 1'b0;
		rx_frame({8'h00, 8'h5A});
		sess({8'h00, 8'h00, 8'h00, 8'h00}, r);
		cmp(r[2:$], {8'h02, 8'h3C});
		dyn_protect_en <= 1'b1;
		rx_frame({8'h01, 8'h4D});
		rx_frame({8'h01, 8'h77});
		sess({8'h00, 8'h00, 8'h00, 8'h00}, r);
		cmp(r[2:$], {8'h01, 8'h4D});
		dyn_protect_en <= 1'b0;
	endtask
	task automatic s_underrun;
		logic [7:0] r;
		int n;
		xfer(8'h40, 1'b1, 1'b0, r);
		xfer(8'h00, 1'b0, 1'b0, r);
		n = irqs;
		bb_rx_start <= 1'b1;
		@(posedge pclk);
		bb_rx_start <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(irqs, n + 1);
		xfer(8'h00, 1'b0, 1'b1, r);
		xfer(8'h00, 1'b1, 1'b0, r);
		xfer(8'h00, 1'b0, 1'b0, r);
		n = irqs;
		bb_rx_start <= 1'b1;
		@(posedge pclk);
		bb_rx_start <= 1'b0;
		xfer(8'h00, 1'b0, 1'b1, r);
		chk(irqs, n);
	endtask
	task automatic s_overflow;
		logic [7:0] r[$];
		int n;
		n = irqs;
		sess({8'hC0, 8'h80, 8'h11}, r);
		chk(irqs, n + 1);
	endtask
	task automatic s_power;
		logic [31:0] q;
		logic [7:0] r[$];
		logic e;
		trx_pon <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			host_clock_output_on <= k[0];
			apb(1'b0, HOST_STAT_OFS, 32'h0, q, e);
			chk(q[STAT_OK_BIT], k);
		end
		trx_pon <= 1'b0;
		trx_sleep <= 1'b1;
		apb(1'b1, HOST_XFER_OFS, 32'h3C0, q, e);
		apb(1'b0, HOST_STAT_OFS, 32'h0, q, e);
		chk(q[2:0], 3'h0);
		apb(1'b0, 12'h010, 32'h0, q, e);
		chk(e, 1'b1);
		trx_sleep <= 1'b0;
		sess({8'h00, 8'h00, 8'h00, 8'h00}, r);
		cmp(r[2:$], {8'h00, 8'h00});
	endtask
	// ********
	// main sequence
	// ********
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		{trx_sleep, trx_pon, pll_on_protect, dyn_protect_en, auto_retry_wait_ack} = 0;
		{tx_auto_crc_on, bb_rx_start, bb_rx_valid, bb_rx_end, bb_rx_data} = 0;
		{bb_tx_start, bb_tx_req} = 0;
		host_clock_output_on = 1'b1;
		bb_rx_lqi = 8'h55;
		bb_rx_ed = 8'h66;
		bb_rx_status = 8'h77;
		bb_tx_fcs = 8'h9E;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		s_store();
		s_tx();
		s_rx();
		s_underrun();
		s_overflow();
		s_power();
		results();
	end
endmodule
`default_nettype wire
